// [src/lcso_top.sv]
module lcso_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cell_clk,
  input wire logic element_gate_enable,
  input wire logic [lcso_pkg::NUM_ELEM-1:0] gate_en_used,
  input wire logic set_reset_input,
  input wire logic set_reset_used,
  input wire logic global_init,
  input wire logic [lcso_pkg::NUM_ELEM-1:0] elem_d,
  input wire logic cfg_latch,
  input wire logic [lcso_pkg::NUM_ELEM-1:0] cfg_clk_inv,
  input wire logic [lcso_pkg::NUM_ELEM-1:0] cfg_init_set,
  output logic [lcso_pkg::NUM_ELEM-1:0] elem_q,
  input wire logic float_pin,
  input wire logic float_pin_inv,
  input wire logic float_from_node,
  input wire logic float_node,
  input wire logic bscan_en,
  input wire logic bscan_extest,
  input wire logic config_done,
  input wire logic [lcso_pkg::NUM_PADS-1:0] out_data,
  input wire logic [lcso_pkg::NUM_PADS-1:0] out_float,
  input wire logic [lcso_pkg::NUM_PADS-1:0] out_fast_cfg,
  output logic [lcso_pkg::NUM_PADS-1:0] pad_o,
  output logic [lcso_pkg::NUM_PADS-1:0] pad_oe_n,
  output logic [lcso_pkg::NUM_PADS-1:0] pad_fast,
  output logic global_output_float,
  output logic outputs_live
);

  typedef struct packed {
    logic [2:0] sync;
    logic float_pin_q;
    lcso_pkg::lcso_start_t start;
    logic [lcso_pkg::SOFT_CNT_W-1:0] soft_cnt;
    logic [lcso_pkg::NUM_PADS-1:0] pad_o;
    logic [lcso_pkg::NUM_PADS-1:0] pad_oe_n;
    logic [lcso_pkg::NUM_PADS-1:0] pad_fast;
  } lcso_top_st_t;

  lcso_top_st_t st_r;
  lcso_top_st_t st_nxt;
  logic float_src;
  logic float_eff;

  // True while start-up has not begun and every pad stays floated.
  function automatic logic lcso_is_unconf(input lcso_pkg::lcso_start_t s);
    return (s == lcso_pkg::LCSO_UNCONF);
  endfunction

  // Storage elements of the cell.
  genvar gi;
  generate
    for (gi = 0; gi < lcso_pkg::NUM_ELEM; gi++) begin : g_elem
      lcso_elem u_elem (
        .clk(clk),
        .rst_n(rst_n),
        .cell_clk(cell_clk),
        .element_gate_enable(element_gate_enable),
        .gate_en_used(gate_en_used[gi]),
        .set_reset_input(set_reset_input),
        .set_reset_used(set_reset_used),
        .global_init(global_init),
        .d(elem_d[gi]),
        .cfg_latch(cfg_latch),
        .cfg_clk_inv(cfg_clk_inv[gi]),
        .cfg_init_set(cfg_init_set[gi]),
        .q(elem_q[gi])
      );
    end
  endgenerate

  // Float source: the filtered pin, optionally inverted, or an internal node.
  assign float_src = float_from_node ? float_node : (st_r.float_pin_q ^ float_pin_inv);
  assign float_eff = float_src & ~(bscan_en & bscan_extest);

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync = {st_r.sync[1:0], float_pin};
    if (st_r.sync[1] == st_r.sync[2]) begin
      st_nxt.float_pin_q = st_r.sync[2];
    end
    case (st_r.start)
      lcso_pkg::LCSO_UNCONF: begin
        if (config_done) begin
          st_nxt.start = lcso_pkg::LCSO_SOFT;
          st_nxt.soft_cnt = lcso_pkg::RST_SOFT_CNT;
        end
      end
      lcso_pkg::LCSO_SOFT: begin
        if (st_r.soft_cnt == lcso_pkg::SOFT_CNT_LAST) begin
          st_nxt.start = lcso_pkg::LCSO_RUN;
        end else begin
          st_nxt.soft_cnt = st_r.soft_cnt + 4'h1;
        end
      end
      lcso_pkg::LCSO_RUN: begin
        st_nxt.start = lcso_pkg::LCSO_RUN;
      end
      default: begin
        st_nxt.start = lcso_pkg::LCSO_UNCONF;
      end
    endcase
    // Pads are driven from the first activation on; the first one is slew limited.
    if (lcso_is_unconf(st_nxt.start)) begin
      st_nxt.pad_oe_n = lcso_pkg::RST_PAD_OE_N;
      st_nxt.pad_fast = lcso_pkg::RST_PAD_FAST;
    end else begin
      st_nxt.pad_oe_n = (out_float | {lcso_pkg::NUM_PADS{float_eff}});
      if (st_nxt.start == lcso_pkg::LCSO_SOFT) begin
        st_nxt.pad_fast = lcso_pkg::RST_PAD_FAST;
      end else begin
        st_nxt.pad_fast = out_fast_cfg;
      end
    end
    st_nxt.pad_o = out_data;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{sync: lcso_pkg::RST_SYNC, float_pin_q: lcso_pkg::RST_FLOAT_PIN, start: lcso_pkg::LCSO_UNCONF,
                soft_cnt: lcso_pkg::RST_SOFT_CNT, pad_o: lcso_pkg::RST_PAD_O, pad_oe_n: lcso_pkg::RST_PAD_OE_N,
                pad_fast: lcso_pkg::RST_PAD_FAST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pad_o = st_r.pad_o;
  assign pad_oe_n = st_r.pad_oe_n;
  assign pad_fast = st_r.pad_fast;
  assign global_output_float = float_eff;
  assign outputs_live = ~lcso_is_unconf(st_r.start);

endmodule // lcso_top

// [src/lcso_pkg.sv]
package lcso_pkg;

  // Two storage elements per cell, four user output pads.
  localparam int unsigned NUM_ELEM = 2;
  localparam int unsigned NUM_PADS = 4;

  // Value of an element after reset: an initial load is pending.
  localparam logic RST_INIT_PEND = 1'b1;
  localparam logic RST_Q = 1'b0;
  localparam logic RST_CLK_PREV = 1'b0;

  // Soft start-up: outputs are held slew-limited for this many cycles.
  localparam int unsigned SOFT_START_CYCLES = 1;
  localparam int unsigned SOFT_CNT_W = 4;
  localparam logic [SOFT_CNT_W-1:0] SOFT_CNT_LAST = SOFT_CNT_W'(SOFT_START_CYCLES - 1);
  localparam logic [SOFT_CNT_W-1:0] RST_SOFT_CNT = 4'h0;

  // Reset values of the output side.
  localparam logic [NUM_PADS-1:0] RST_PAD_O = 4'h0;
  localparam logic [NUM_PADS-1:0] RST_PAD_OE_N = 4'hf;
  localparam logic [NUM_PADS-1:0] RST_PAD_FAST = 4'h0;
  localparam logic [2:0] RST_SYNC = 3'h0;
  localparam logic RST_FLOAT_PIN = 1'b0;

  typedef enum logic [1:0] {
    LCSO_UNCONF = 2'h0,
    LCSO_SOFT = 2'h1,
    LCSO_RUN = 2'h3
  } lcso_start_t;

endpackage

// [src/lcso_elem.sv]
module lcso_elem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cell_clk,
  input wire logic element_gate_enable,
  input wire logic gate_en_used,
  input wire logic set_reset_input,
  input wire logic set_reset_used,
  input wire logic global_init,
  input wire logic d,
  input wire logic cfg_latch,
  input wire logic cfg_clk_inv,
  input wire logic cfg_init_set,
  output logic q
);

  typedef struct packed {
    logic clk_prev;
    logic q;
    logic init_pend;
  } lcso_elem_st_t;

  lcso_elem_st_t st_r;
  lcso_elem_st_t st_nxt;
  logic ck_eff;
  logic en_eff;
  logic sr_eff;
  logic force_init;

  // Per-element clock polarity; the enable has no inversion.
  assign ck_eff = cell_clk ^ cfg_clk_inv;
  assign en_eff = element_gate_enable | ~gate_en_used;
  assign sr_eff = set_reset_input & set_reset_used;
  assign force_init = st_r.init_pend | global_init | sr_eff;

  always_comb begin
    st_nxt = st_r;
    st_nxt.clk_prev = ck_eff;
    st_nxt.init_pend = 1'b0;
    if (force_init) begin
      st_nxt.q = cfg_init_set;
    end else if (!en_eff) begin
      st_nxt.q = st_r.q;
    end else if (cfg_latch) begin
      if (!ck_eff) begin
        st_nxt.q = d;
      end
    end else if (ck_eff && !st_r.clk_prev) begin
      st_nxt.q = d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{clk_prev: lcso_pkg::RST_CLK_PREV, q: lcso_pkg::RST_Q, init_pend: lcso_pkg::RST_INIT_PEND};
    end else begin
      st_r <= st_nxt;
    end
  end

  // The forced value shows at once, ahead of any edge or transparency.
  assign q = force_init ? cfg_init_set : st_r.q;

endmodule // lcso_elem

// [sim/lcso_monitor.sv]
module lcso_monitor (
  input logic clk,
  input logic rst_n,
  input logic cell_clk,
  input logic element_gate_enable,
  input logic [1:0] gate_en_used,
  input logic set_reset_input,
  input logic set_reset_used,
  input logic global_init,
  input logic [1:0] elem_d,
  input logic cfg_latch,
  input logic [1:0] cfg_clk_inv,
  input logic [1:0] cfg_init_set,
  input logic [1:0] elem_q,
  input logic bscan_en,
  input logic bscan_extest,
  input logic [3:0] pad_oe_n,
  input logic [3:0] pad_fast,
  input logic global_output_float,
  input logic outputs_live
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire forced = global_init || (set_reset_used && set_reset_input);
  wire en0 = element_gate_enable || !gate_en_used[0];
  wire en1 = element_gate_enable || !gate_en_used[1];
  sr_force_a: assert property (set_reset_used && set_reset_input |-> elem_q == cfg_init_set)
    else $error("q not forced");
  hold_q_a: assert property (!forced && !en0 ##1 !forced |-> $stable(elem_q[0]))
    else $error("q moved while disabled");
  ff_cap_a: assert property (!cfg_latch && !cfg_clk_inv[0] && en0 && !forced && $rose(cell_clk)
    |=> forced || elem_q[0] == $past(elem_d[0])) else $error("rising capture missed");
  inv_cap_a: assert property (!cfg_latch && cfg_clk_inv[1] && en1 && !forced && $fell(cell_clk)
    |=> forced || elem_q[1] == $past(elem_d[1])) else $error("falling capture missed");
  latch_pass_a: assert property (cfg_latch && !cfg_clk_inv[0] && !cell_clk && en0 && !forced
    |=> forced || elem_q[0] == $past(elem_d[0])) else $error("latch not transparent");
  float_pad_a: assert property (global_output_float |=> pad_oe_n == 4'hf)
    else $error("pads not floated");
  extest_a: assert property (bscan_en && bscan_extest |-> !global_output_float)
    else $error("float during extest");
  soft_start_a: assert property ($rose(outputs_live) |-> pad_fast == 4'h0)
    else $error("first activation fast");
  cover property ($rose(outputs_live));
  cover property (global_output_float);
  cover property (cfg_latch && !cell_clk && en0);
endmodule // lcso_monitor
bind lcso_top lcso_monitor u_mon (
  .clk(clk),
  .rst_n(rst_n),
  .cell_clk(cell_clk),
  .element_gate_enable(element_gate_enable),
  .gate_en_used(gate_en_used),
  .set_reset_input(set_reset_input),
  .set_reset_used(set_reset_used),
  .global_init(global_init),
  .elem_d(elem_d),
  .cfg_latch(cfg_latch),
  .cfg_clk_inv(cfg_clk_inv),
  .cfg_init_set(cfg_init_set),
  .elem_q(elem_q),
  .bscan_en(bscan_en),
  .bscan_extest(bscan_extest),
  .pad_oe_n(pad_oe_n),
  .pad_fast(pad_fast),
  .global_output_float(global_output_float),
  .outputs_live(outputs_live)
);

// [sim/lcso_user.sv]
module lcso_user (
  input logic clk,
  input logic run,
  input logic od_sig,
  output logic cell_clk,
  output logic [3:0] out_data,
  output logic [3:0] out_float
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_r = 2'h0;
  // The storage clock toggles every two cycles while running and stands low otherwise.
  always @(posedge clk) div_r <= run ? div_r + 2'h1 : 2'h0;
  assign cell_clk = div_r[1];
  // Pad 3 is open drain: data tied low, its float follows the signal.
  assign out_data = 4'h5;
  assign out_float = {od_sig, 3'h0};
endmodule // lcso_user

// [sim/lcso_tb_top.sv]
module lcso_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, cell_clk, element_gate_enable, set_reset_input, set_reset_used, global_init, cfg_latch;
  logic float_pin, float_pin_inv, float_from_node, float_node, bscan_en, bscan_extest, config_done, run, od_sig;
  logic global_output_float, outputs_live;
  logic [1:0] gate_en_used, elem_d, cfg_clk_inv, cfg_init_set, elem_q;
  logic [3:0] out_data, out_float, out_fast_cfg, pad_o, pad_oe_n, pad_fast;
  int n_fail = 0;
  int num_checks = 0;
  lcso_top uut (.*);
  lcso_user partner (.*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    give_verdict();
  end
  initial begin
    {rst_n, element_gate_enable, set_reset_input, set_reset_used, global_init, cfg_latch} <= 6'h0;
    {float_pin, float_pin_inv, float_from_node, float_node, bscan_en, bscan_extest, config_done, run, od_sig} <= 9'h0;
    {gate_en_used, elem_d, cfg_clk_inv, cfg_init_set, out_fast_cfg} <= 12'h02f;
    tick(4);
    chk(elem_q, 2'h2);
    chk(outputs_live, 1'h0);
    chk(pad_oe_n, 4'hf);
    rst_n <= 1'b1;
    tick(2);
    {set_reset_used, set_reset_input, cfg_init_set} <= 4'hd;
    #1 chk(elem_q, 2'h1);
    tick(1);
    {set_reset_used, cfg_init_set, element_gate_enable, gate_en_used, cfg_clk_inv, elem_d, run} <= 11'h0f7;
    tick(9);
    chk(elem_q, 2'h3);
    {element_gate_enable, gate_en_used, elem_d} <= 5'h04;
    tick(9);
    chk(elem_q, 2'h1);
    {element_gate_enable, cfg_latch, elem_d} <= 4'he;
    tick(9);
    chk(elem_q, 2'h2);
    run <= 1'b0;
    tick(2);
    elem_d <= 2'h1;
    tick(4);
    chk(elem_q, 2'h3);
    {global_init, cfg_latch} <= 2'h2;
    #1 chk(elem_q, 2'h0);
    tick(1);
    {global_init, config_done, od_sig} <= 3'h3;
    tick(1);
    #1 chk(pad_fast, 4'h0);
    chk(outputs_live, 1'h1);
    tick(2);
    #1 chk(pad_fast, 4'hf);
    chk(pad_oe_n, 4'h8);
    chk(pad_o, 4'h5);
    tick(1);
    {float_from_node, float_node} <= 2'h3;
    tick(2);
    #1 chk(pad_oe_n, 4'hf);
    chk(global_output_float, 1'h1);
    tick(1);
    {bscan_en, bscan_extest} <= 2'h3;
    tick(2);
    #1 chk(pad_oe_n, 4'h8);
    chk(global_output_float, 1'h0);
    tick(1);
    {bscan_en, float_from_node, float_pin_inv, od_sig} <= 4'h2;
    tick(7);
    #1 chk(pad_oe_n, 4'hf);
    tick(1);
    float_pin <= 1'b1;
    tick(7);
    #1 chk(pad_oe_n, 4'h0);
    give_verdict();
  end
endmodule // lcso_tb_top
